// ==== rtl/track_jump_sequencer.v ====
// Functional notes
// [R1] Each jump: accel, decel, optional brake, then done.
// [R2] Variant 1: 233 us accel, 233 us decel, 60 ms brake.
// [R3] Variant 2: half-period accel; decel 233 us old, half period new; 60 ms brake.
// [R4] Variant 3: variant 2 timing, no brake.
// [R5] Variant 4: variant 2 timing, 60 ms brake, tracking-off low.
// [R6] Two-track: new mode only, one period each, brake per selection.
// [R7] Four-track: accel 2 periods; decel 466 us old, 2 periods new; 60 ms brake.
// [R8] Sixteen-track: accel 9 periods; decel 7 old, 9 new; 60 ms brake.
// [R9] 32/64/128 tracks: 18/14, 36/28, 72/56 periods, 60 ms brake.
// [R10] 256 check: no drive, tracking-off high for 256 crossings, 60 ms brake.
// [R11] Jump-brake command: 60 ms brake only.
// [R12] Selectable 60 ms brake: two commands; off after reset.
// [R13] Brakeless jumps need an external brake.
// [R14] Command register clears after a full sequence.
// [R15] A new jump aborts the running one at once.
// [R16] Brake: mirror sampled on error edges; mirror-to-data high, data-to-mirror low.
// [R17] Three-level single-pin or two-pin drive; two-pin after reset.
// [R18] Track check in/out is followed by a count byte, 8 to 254.
// [R19] Strobe falling edge after the count starts the check.
// [R20] Tracking-off high while a check runs.
// [R21] Host flag rises at half count, falls at completion.
// [R22] Check repeats until the two-byte reset; reset state by default. The code ends it on the single C_CHK_RESET byte.
// [R23] Host should send jump-brake after a check.
// [R24] Tracking-off low only in constant linear velocity mode.
// [R25] Track period is clock count between crossings, scaled per phase.
`timescale 1ns/1ns
`default_nettype none
`include "tjs_defs.vh"

module track_jump_sequencer #(
   parameter ADDR_W = 4,
   parameter PER_W = 24,
   parameter [31:0] KICK_CYC = `T_KICK_US * `CLK_MHZ,
   parameter [31:0] KICK_LONG_CYC = `T_KICK_LONG_US * `CLK_MHZ,
   parameter [31:0] BRAKE_CYC = `T_BRAKE_MS * 1000 * `CLK_MHZ
)(
   // Clock and reset
   input wire I_CLK,
   input wire I_NRST,
   // AXI4-Lite write address and data
   input wire I_AWVALID,
   output wire O_AWREADY,
   input wire [ADDR_W-1:0] I_AWADDR,
   input wire [2:0] I_AWPROT,
   input wire I_WVALID,
   output wire O_WREADY,
   input wire [31:0] I_WDATA,
   input wire [3:0] I_WSTRB,
   // AXI4-Lite write response
   output wire O_BVALID,
   input wire I_BREADY,
   output wire [1:0] O_BRESP,
   // AXI4-Lite read
   input wire I_ARVALID,
   output wire O_ARREADY,
   input wire [ADDR_W-1:0] I_ARADDR,
   input wire [2:0] I_ARPROT,
   output wire O_RVALID,
   input wire I_RREADY,
   output wire [31:0] O_RDATA,
   output wire [1:0] O_RRESP,
   // Servo front end and disc motor state
   input wire I_TRACK_ERROR_SIGN_IN,
   input wire I_MIRROR_DETECT_IN,
   input wire I_CLV_MODE,
   input wire I_HOST_COMMAND_STROBE_IN,
   // Actuator and loop control
   output wire O_JUMP_DRIVE_POS,
   output wire O_JUMP_DRIVE_POS_OE,
   output wire O_JUMP_DRIVE_NEG,
   output wire O_TRACKING_LOOP_OFF_OUT,
   output wire O_TRACKING_GAIN_BOOST_OUT,
   output wire O_TRACKING_HOLD_OUT,
   output wire O_HOST_STATUS_FLAG_OUT
);

   // ********
   // States
   // ********
   localparam [4:0] S_IDLE = 5'h01;
   localparam [4:0] S_ACCEL = 5'h02;
   localparam [4:0] S_DECEL = 5'h04;
   localparam [4:0] S_BRAKE = 5'h08;
   localparam [4:0] S_CHECK = 5'h10;

   // Phase length from a period multiple in half periods, or fixed time
   function [31:0] phase_cyc;
      input [7:0] halves;
      input [1:0] sel;
      input [PER_W-1:0] per;
      reg [31:0] p;
      begin
         p = ({{(32-PER_W){1'b0}}, per} * {24'h000000, halves}) >> 1;
         if (sel == `BSEL_SHORT)
            phase_cyc = KICK_CYC;
         else if (sel == `BSEL_LONG)
            phase_cyc = KICK_LONG_CYC;
         else if (p == 32'h0)
            phase_cyc = 32'h1;
         else
            phase_cyc = p;
      end
   endfunction

   // ********
   // Input synchronisers
   // ********
   reg [1:0] tes_sync_r;
   reg [1:0] hfl_sync_r;
   reg [1:0] clv_sync_r;
   reg [1:0] stb_sync_r;
   reg tes_d_r;
   reg stb_d_r;
   wire tes_s = tes_sync_r[1];
   wire tes_rise = tes_s & ~tes_d_r;
   wire tes_edge = tes_s ^ tes_d_r;
   wire stb_fall = ~stb_sync_r[1] & stb_d_r;
   wire clv_s = clv_sync_r[1];

   // Two flip-flops per pin, then edge history
   always @(posedge I_CLK or negedge I_NRST)
   begin
      if (!I_NRST)
      begin
         tes_sync_r <= 2'h0;
         hfl_sync_r <= 2'h0;
         clv_sync_r <= 2'h0;
         stb_sync_r <= 2'h3;
         tes_d_r <= 1'b0;
         stb_d_r <= 1'b1;
      end
      else
      begin
         tes_sync_r <= {tes_sync_r[0], I_TRACK_ERROR_SIGN_IN};
         hfl_sync_r <= {hfl_sync_r[0], I_MIRROR_DETECT_IN};
         clv_sync_r <= {clv_sync_r[0], I_CLV_MODE};
         stb_sync_r <= {stb_sync_r[0], I_HOST_COMMAND_STROBE_IN};
         tes_d_r <= tes_s;
         stb_d_r <= stb_sync_r[1];
      end
   end

   // ********
   // Track period measurement and brake slip detect
   // ********
   reg [PER_W-1:0] per_cnt_r;
   reg [PER_W-1:0] period_r;
   reg hfl_prev_r;
   reg slip_tracking_loop_off_out_r;

   // Cycles between rising crossings, saturating
   always @(posedge I_CLK or negedge I_NRST)
   begin
      if (!I_NRST)
      begin
         per_cnt_r <= {PER_W{1'b0}};
         period_r <= {PER_W{1'b0}};
         hfl_prev_r <= 1'b0;
         slip_tracking_loop_off_out_r <= 1'b1;
      end
      else
      begin
         if (tes_rise)
         begin
            period_r <= per_cnt_r; // R25
            per_cnt_r <= {{(PER_W-1){1'b0}}, 1'b1};
         end
         else if (~&per_cnt_r)
            per_cnt_r <= per_cnt_r + 1'b1;
         // Mirror level taken on each error edge
         if (tes_edge)
         begin
            hfl_prev_r <= hfl_sync_r[1];
            if (hfl_prev_r && !hfl_sync_r[1])
               slip_tracking_loop_off_out_r <= 1'b1; // R16
            else if (!hfl_prev_r && hfl_sync_r[1])
               slip_tracking_loop_off_out_r <= 1'b0; // R16
         end
      end
   end

   // ********
   // AXI4-Lite slave
   // ********
   reg aw_have_r;
   reg w_have_r;
   reg [ADDR_W-1:0] aw_addr_r;
   reg [31:0] w_data_r;
   reg w_lane0_r;
   reg bvalid_r;
   reg [1:0] bresp_r;
   reg rvalid_r;
   reg [31:0] rdata_r;
   reg [1:0] rresp_r;
   wire wr_go = aw_have_r & w_have_r & ~bvalid_r;
   wire cmd_we = wr_go & (aw_addr_r == `OFS_CMD) & w_lane0_r;
   wire [7:0] cmd_byte = w_data_r[7:0];

   assign O_AWREADY = ~aw_have_r;
   assign O_WREADY = ~w_have_r;
   assign O_BVALID = bvalid_r;
   assign O_BRESP = bresp_r;
   assign O_ARREADY = ~rvalid_r;
   assign O_RVALID = rvalid_r;
   assign O_RDATA = rdata_r;
   assign O_RRESP = rresp_r;

   // ********
   // Sequencer state
   // ********
   reg [4:0] state_r;
   reg [31:0] timer_r;
   reg [7:0] cmd_r;
   reg dir_out_r;
   reg [7:0] b_half_r;
   reg [1:0] b_sel_r;
   reg [1:0] brk_r;
   reg new_mode_r;
   reg brake_sel_r;
   reg three_r;
   reg loop_off_cmd_r;
   reg chk_pend_r;
   reg chk_armed_r;
   reg chk_rep_r;
   reg chk_dir_r;
   reg [7:0] chk_target_r;
   reg [8:0] chk_cnt_r;
   reg flag_r;
   reg [31:0] stat;

   // Jump command decode
   reg jv;
   reg [7:0] ja;
   reg [7:0] jb;
   reg [1:0] jbs;
   reg [1:0] jbk;
   always @*
   begin
      jv = 1'b1;
      ja = 8'h00;
      jb = 8'h00;
      jbs = `BSEL_PER;
      jbk = `BRK_60;
      case ({cmd_byte[7:4], 1'b0, cmd_byte[2:0]})
         `JB_1A: jbs = `BSEL_SHORT; // R2
         `JB_1B, `JB_1C, `JB_1D:
         begin
            ja = 8'h01; // R3
            jb = 8'h01;
            jbs = new_mode_r ? `BSEL_PER : `BSEL_SHORT;
            if (cmd_byte[5:4] == 2'h3)
               jbk = `BRK_NONE; // R4
            else if (cmd_byte[6])
               jbk = `BRK_TOFFL; // R5
         end
         `JB_2:
         begin
            jv = new_mode_r; // R6
            ja = 8'h02;
            jb = 8'h02;
            jbk = `BRK_SEL;
         end
         `JB_4:
         begin
            ja = 8'h04; // R7
            jb = 8'h04;
            jbs = new_mode_r ? `BSEL_PER : `BSEL_LONG;
         end
         `JB_16:
         begin
            ja = 8'h12; // R8
            jb = new_mode_r ? 8'h12 : 8'h0e;
         end
         `JB_32:
         begin
            ja = 8'h24; // R9
            jb = 8'h1c;
         end
         `JB_64:
         begin
            ja = 8'h48; // R9
            jb = 8'h38;
         end
         `JB_128:
         begin
            ja = 8'h90; // R9
            jb = 8'h70;
         end
         default: jv = 1'b0;
      endcase
   end

   wire timer_done = (timer_r == 32'h1);
   wire [8:0] cnt_inc = chk_cnt_r + 1'b1;

   // Command intake, phase sequencing and track checking
   always @(posedge I_CLK or negedge I_NRST)
   begin
      if (!I_NRST)
      begin
         state_r <= S_IDLE;
         timer_r <= 32'h0;
         cmd_r <= 8'h00;
         dir_out_r <= 1'b0;
         b_half_r <= 8'h00;
         b_sel_r <= `BSEL_PER;
         brk_r <= `BRK_NONE;
         new_mode_r <= 1'b0;
         brake_sel_r <= 1'b0;
         three_r <= 1'b0;
         loop_off_cmd_r <= 1'b0;
         chk_pend_r <= 1'b0;
         chk_armed_r <= 1'b0;
         chk_rep_r <= 1'b0;
         chk_dir_r <= 1'b0;
         chk_target_r <= 8'h00;
         chk_cnt_r <= 9'h000;
         flag_r <= 1'b0;
      end
      else if (cmd_we && chk_pend_r)
      begin
         chk_target_r <= cmd_byte; // R18
         chk_pend_r <= 1'b0;
         chk_armed_r <= 1'b1;
      end
      else if (cmd_we && (cmd_byte == `C_CHK_IN || cmd_byte == `C_CHK_OUT))
      begin
         chk_pend_r <= 1'b1; // R18
         chk_armed_r <= 1'b0;
         chk_dir_r <= cmd_byte[3];
         cmd_r <= cmd_byte;
      end
      else if (cmd_we && cmd_byte == `C_CHK_RESET)
      begin
         chk_pend_r <= 1'b0; // R22
         chk_armed_r <= 1'b0;
         flag_r <= 1'b0;
         if (chk_rep_r)
         begin
            chk_rep_r <= 1'b0;
            state_r <= S_IDLE;
            cmd_r <= 8'h00;
         end
      end
      else if (cmd_we && (jv || cmd_byte == `C_CHK256 || cmd_byte == `C_JUMP_BRAKE))
      begin
         // Any jump restarts the sequencer at once
         cmd_r <= cmd_byte; // R15
         chk_rep_r <= 1'b0;
         chk_cnt_r <= 9'h000;
         dir_out_r <= cmd_byte[3];
         b_half_r <= jb;
         b_sel_r <= jbs;
         brk_r <= jbk;
         if (cmd_byte == `C_CHK256)
            state_r <= S_CHECK; // R10
         else if (cmd_byte == `C_JUMP_BRAKE)
         begin
            state_r <= S_BRAKE; // R11
            brk_r <= `BRK_60;
            timer_r <= BRAKE_CYC;
         end
         else
         begin
            state_r <= S_ACCEL; // R1
            timer_r <= phase_cyc(ja, (ja == 8'h00) ? `BSEL_SHORT : `BSEL_PER, period_r);
         end
      end
      else
      begin
         // Mode commands
         if (cmd_we)
         begin
            case (cmd_byte)
               `C_JUMP_PREV: new_mode_r <= 1'b0;
               `C_JUMP_NEW: new_mode_r <= 1'b1;
               `C_BRK_OFF: brake_sel_r <= 1'b0; // R12
               `C_BRK_ON: brake_sel_r <= 1'b1; // R12
               `C_JP_THREE: three_r <= 1'b1; // R17
               `C_JP_TWO: three_r <= 1'b0; // R17
               `C_LOOP_OFF: loop_off_cmd_r <= 1'b1;
               `C_LOOP_ON: loop_off_cmd_r <= 1'b0;
               default: ;
            endcase
         end
         // Strobe fall starts an armed track check
         if (stb_fall && chk_armed_r)
         begin
            chk_armed_r <= 1'b0; // R19
            chk_rep_r <= 1'b1;
            chk_cnt_r <= 9'h000;
            flag_r <= 1'b0;
            state_r <= S_CHECK;
         end
         else
         begin
            case (state_r)
               S_IDLE: timer_r <= 32'h0;
               S_ACCEL:
                  if (timer_done)
                  begin
                     state_r <= S_DECEL; // R1
                     timer_r <= phase_cyc(b_half_r, b_sel_r, period_r);
                  end
                  else
                     timer_r <= timer_r - 1'b1;
               S_DECEL:
                  if (timer_done)
                  begin
                     if (brk_r == `BRK_NONE || (brk_r == `BRK_SEL && !brake_sel_r))
                     begin
                        state_r <= S_IDLE; // R4
                        cmd_r <= 8'h00; // R14
                     end
                     else
                     begin
                        state_r <= S_BRAKE; // R1
                        timer_r <= BRAKE_CYC;
                     end
                  end
                  else
                     timer_r <= timer_r - 1'b1;
               S_BRAKE:
                  if (timer_done)
                  begin
                     state_r <= S_IDLE;
                     cmd_r <= 8'h00; // R14
                  end
                  else
                     timer_r <= timer_r - 1'b1;
               S_CHECK:
                  if (tes_rise)
                  begin
                     if (!chk_rep_r)
                     begin
                        chk_cnt_r <= cnt_inc;
                        if (cnt_inc == `CHK256_COUNT)
                        begin
                           state_r <= S_BRAKE; // R10
                           brk_r <= `BRK_60;
                           timer_r <= BRAKE_CYC;
                        end
                     end
                     else if (cnt_inc[7:0] == chk_target_r)
                     begin
                        flag_r <= 1'b0; // R21
                        chk_cnt_r <= 9'h000; // R22
                     end
                     else
                     begin
                        chk_cnt_r <= cnt_inc;
                        if (cnt_inc[7:0] == {1'b0, chk_target_r[7:1]})
                           flag_r <= 1'b1; // R21
                     end
                  end
               default: state_r <= S_IDLE;
            endcase
         end
      end
   end

   // ********
   // Output stage
   // ********
   reg jp_pos_r;
   reg jp_neg_r;
   reg jp_oe_r;
   reg tracking_loop_off_out_r;
   reg gain_r;
   reg hold_r;
   reg host_flag_r;
   wire kick_a = (state_r == S_ACCEL);
   wire kick_b = (state_r == S_DECEL);
   wire push_pos = (kick_a & ~dir_out_r) | (kick_b & dir_out_r);
   wire push_neg = (kick_a & dir_out_r) | (kick_b & ~dir_out_r);
   wire chk_mode = chk_pend_r | chk_armed_r | chk_rep_r;

   // Registered pin drive
   always @(posedge I_CLK or negedge I_NRST)
   begin
      if (!I_NRST)
      begin
         jp_pos_r <= 1'b0;
         jp_neg_r <= 1'b0;
         jp_oe_r <= 1'b1;
         tracking_loop_off_out_r <= 1'b1;
         gain_r <= 1'b0;
         hold_r <= 1'b0;
         host_flag_r <= 1'b0;
      end
      else
      begin
         if (three_r)
         begin
            jp_pos_r <= push_pos; // R17
            jp_oe_r <= push_pos | push_neg;
            jp_neg_r <= 1'b0;
         end
         else
         begin
            jp_pos_r <= push_pos;
            jp_oe_r <= 1'b1;
            jp_neg_r <= push_neg;
         end
         if (!clv_s)
            tracking_loop_off_out_r <= 1'b1; // R24
         else if (kick_a || kick_b || state_r == S_CHECK)
            tracking_loop_off_out_r <= 1'b1; // R20
         else if (state_r == S_BRAKE)
            tracking_loop_off_out_r <= (brk_r == `BRK_TOFFL) ? 1'b0 : slip_tracking_loop_off_out_r; // R5
         else
            tracking_loop_off_out_r <= loop_off_cmd_r;
         gain_r <= (state_r == S_BRAKE);
         hold_r <= kick_a | kick_b;
         host_flag_r <= chk_mode & flag_r; // R21
      end
   end

   assign O_JUMP_DRIVE_POS = jp_pos_r;
   assign O_JUMP_DRIVE_POS_OE = jp_oe_r;
   assign O_JUMP_DRIVE_NEG = jp_neg_r;
   assign O_TRACKING_LOOP_OFF_OUT = tracking_loop_off_out_r;
   assign O_TRACKING_GAIN_BOOST_OUT = gain_r;
   assign O_TRACKING_HOLD_OUT = hold_r;
   assign O_HOST_STATUS_FLAG_OUT = host_flag_r;

   // Status word
   always @*
   begin
      stat = 32'h0;
      stat[`ST_STATE_LSB+4:`ST_STATE_LSB] = state_r;
      stat[`ST_NEW_MODE] = new_mode_r;
      stat[`ST_BRAKE_SEL] = brake_sel_r;
      stat[`ST_THREE_LEVEL] = three_r;
      stat[`ST_CHK_PEND] = chk_pend_r;
      stat[`ST_CHK_ARMED] = chk_armed_r;
      stat[`ST_HOST_FLAG] = host_flag_r;
      stat[`ST_TRACKING_LOOP_OFF_OUT] = tracking_loop_off_out_r;
      stat[`ST_CLV] = clv_s;
   end

   // Bus channel handling, one write and one read at a time
   always @(posedge I_CLK or negedge I_NRST)
   begin
      if (!I_NRST)
      begin
         aw_have_r <= 1'b0;
         w_have_r <= 1'b0;
         aw_addr_r <= {ADDR_W{1'b0}};
         w_data_r <= 32'h0;
         w_lane0_r <= 1'b0;
         bvalid_r <= 1'b0;
         bresp_r <= `RESP_OKAY;
         rvalid_r <= 1'b0;
         rdata_r <= 32'h0;
         rresp_r <= `RESP_OKAY;
      end
      else
      begin
         if (I_AWVALID && !aw_have_r)
         begin
            aw_have_r <= 1'b1;
            aw_addr_r <= I_AWADDR;
         end
         else if (wr_go)
            aw_have_r <= 1'b0;
         if (I_WVALID && !w_have_r)
         begin
            w_have_r <= 1'b1;
            w_data_r <= I_WDATA;
            w_lane0_r <= I_WSTRB[0];
         end
         else if (wr_go)
            w_have_r <= 1'b0;
         if (wr_go)
         begin
            bvalid_r <= 1'b1;
            bresp_r <= (aw_addr_r == `OFS_CMD) ? `RESP_OKAY : `RESP_DECERR;
         end
         else if (I_BREADY)
            bvalid_r <= 1'b0;
         if (I_ARVALID && !rvalid_r)
         begin
            rvalid_r <= 1'b1;
            rresp_r <= `RESP_OKAY;
            case (I_ARADDR)
               `OFS_CMD: rdata_r <= {24'h000000, cmd_r};
               `OFS_STAT: rdata_r <= stat;
               `OFS_PERIOD: rdata_r <= {{(32-PER_W){1'b0}}, period_r};
               default:
               begin
                  rdata_r <= 32'h0;
                  rresp_r <= `RESP_DECERR;
               end
            endcase
         end
         else if (I_RREADY)
            rvalid_r <= 1'b0;
      end
   end

endmodule

`default_nettype wire

// ==== rtl/tjs_defs.vh ====
`ifndef TJS_DEFS_VH
`define TJS_DEFS_VH

// ********
// Clock and timing
// ********
`define CLK_MHZ 125
`define T_KICK_US 233
`define T_KICK_LONG_US 466
`define T_BRAKE_MS 60
`define CHK256_COUNT 9'h100

// ********
// Register offsets (byte addresses)
// ********
`define OFS_CMD 4'h0
`define OFS_STAT 4'h4
`define OFS_PERIOD 4'h8

// Status register fields
`define ST_STATE_LSB 0
`define ST_NEW_MODE 5
`define ST_BRAKE_SEL 6
`define ST_THREE_LEVEL 7
`define ST_CHK_PEND 8
`define ST_CHK_ARMED 9
`define ST_HOST_FLAG 10
`define ST_TRACKING_LOOP_OFF_OUT 11
`define ST_CLV 12

// AXI responses
`define RESP_OKAY 2'h0
`define RESP_DECERR 2'h3

// ********
// Command codes
// ********
`define C_JUMP_PREV 8'ha0
`define C_JUMP_NEW 8'ha1
`define C_BRK_OFF 8'hf6
`define C_BRK_ON 8'h7f
`define C_JP_THREE 8'hb6
`define C_JP_TWO 8'hb7
`define C_LOOP_OFF 8'h0f
`define C_LOOP_ON 8'h8f
`define C_CHK_IN 8'hf0
`define C_CHK_OUT 8'hf8
`define C_CHK_RESET 8'hff
`define C_CHK256 8'h16
`define C_JUMP_BRAKE 8'h8c

// Jump codes with the direction bit (bit 3) cleared
`define JB_1A 8'h11
`define JB_1B 8'h12
`define JB_1C 8'h31
`define JB_1D 8'h52
`define JB_2 8'h10
`define JB_4 8'h13
`define JB_16 8'h14
`define JB_32 8'h30
`define JB_64 8'h15
`define JB_128 8'h17

// Deceleration length source
`define BSEL_PER 2'h0
`define BSEL_SHORT 2'h1
`define BSEL_LONG 2'h2

// Braking phase kinds
`define BRK_NONE 2'h0
`define BRK_60 2'h1
`define BRK_TOFFL 2'h2
`define BRK_SEL 2'h3

`endif

// ==== bench/servo_front_end.sv ====
// ********
// Servo front end: error sign and mirror flag
// ********
`timescale 1ns/1ns
`default_nettype none
module servo_front_end #(
   parameter int HALF = 10
)(
   input wire logic clk,
   output logic err_sign,
   output logic mirror
);
   int cnt = 0;
   // One track crossing every 2*HALF cycles
   always @(posedge clk)
      cnt <= (cnt + 1) % (2 * HALF);
   // Square error sign, mirror flag a quarter track ahead
   assign err_sign = cnt < HALF;
   assign mirror = ((cnt + HALF / 2) % (2 * HALF)) < HALF;
endmodule
`default_nettype wire

// ==== bench/track_jump_sequencer_sva.sv ====
// ********
// Port checker for the jump sequencer
// ********
`timescale 1ns/1ns
`default_nettype none
module tjs_checker #(
   parameter BRAKE_CYC = 100
)(
   // Clock and inputs
   input wire logic I_CLK,
   input wire logic I_NRST,
   input wire logic I_CLV_MODE,
   input wire logic I_BREADY,
   // Watched outputs
   input wire logic O_BVALID,
   input wire logic [1:0] O_BRESP,
   input wire logic O_JUMP_DRIVE_POS,
   input wire logic O_JUMP_DRIVE_POS_OE,
   input wire logic O_JUMP_DRIVE_NEG,
   input wire logic O_TRACKING_LOOP_OFF_OUT,
   input wire logic O_TRACKING_GAIN_BOOST_OUT,
   input wire logic O_TRACKING_HOLD_OUT,
   input wire logic O_HOST_STATUS_FLAG_OUT
);
   logic [31:0] brk_r;
   default clocking @(posedge I_CLK);
   endclocking
   default disable iff (!I_NRST);
   // Length of the running braking phase
   always @(posedge I_CLK or negedge I_NRST)
      if (!I_NRST)
         brk_r <= 32'h0;
      else
         brk_r <= O_TRACKING_GAIN_BOOST_OUT ? brk_r + 32'h1 : 32'h0;
   // Phase and pin relations
   a_drive_excl: assert property (!(O_JUMP_DRIVE_POS && O_JUMP_DRIVE_NEG))
      else $error("both kick pins high");
   a_phase_excl: assert property (!(O_TRACKING_HOLD_OUT && O_TRACKING_GAIN_BOOST_OUT))
      else $error("hold and brake together");
   a_kick_hold: assert property (O_JUMP_DRIVE_POS && O_JUMP_DRIVE_POS_OE || O_JUMP_DRIVE_NEG
      |-> O_TRACKING_HOLD_OUT)
      else $error("kick outside accel or decel");
   a_neg_oe: assert property (O_JUMP_DRIVE_NEG |-> O_JUMP_DRIVE_POS_OE)
      else $error("negative kick in single pin mode");
   a_clv_off: assert property (!I_CLV_MODE [*6] |-> O_TRACKING_LOOP_OFF_OUT)
      else $error("loop closed outside CLV");
   a_flag_off: assert property (O_HOST_STATUS_FLAG_OUT |-> O_TRACKING_LOOP_OFF_OUT)
      else $error("loop closed during check");
   a_brake_len: assert property (brk_r <= BRAKE_CYC)
      else $error("brake too long");
   a_resp_hold: assert property (O_BVALID && !I_BREADY |=> O_BVALID && $stable(O_BRESP))
      else $error("write response dropped");
   c_brake: cover property ($rose(O_TRACKING_GAIN_BOOST_OUT));
   c_flag: cover property ($rose(O_HOST_STATUS_FLAG_OUT));
   c_neg: cover property ($rose(O_JUMP_DRIVE_NEG));
endmodule
bind track_jump_sequencer tjs_checker #(.BRAKE_CYC(BRAKE_CYC)) u_tjs_checker (
   .I_CLK(I_CLK), .I_NRST(I_NRST), .I_CLV_MODE(I_CLV_MODE), .I_BREADY(I_BREADY),
   .O_BVALID(O_BVALID), .O_BRESP(O_BRESP), .O_JUMP_DRIVE_POS(O_JUMP_DRIVE_POS),
   .O_JUMP_DRIVE_POS_OE(O_JUMP_DRIVE_POS_OE), .O_JUMP_DRIVE_NEG(O_JUMP_DRIVE_NEG),
   .O_TRACKING_LOOP_OFF_OUT(O_TRACKING_LOOP_OFF_OUT),
   .O_TRACKING_GAIN_BOOST_OUT(O_TRACKING_GAIN_BOOST_OUT),
   .O_TRACKING_HOLD_OUT(O_TRACKING_HOLD_OUT), .O_HOST_STATUS_FLAG_OUT(O_HOST_STATUS_FLAG_OUT));
`default_nettype wire

// ==== bench/track_jump_sequencer_bench.sv ====
// ********
// Self-checking bench for the jump sequencer
// ********
`timescale 1ns/1ns
`default_nettype none
module track_jump_sequencer_bench;
   localparam int P = 20;
   localparam int K = 20;
   localparam int KL = 40;
   localparam int B = 100;
   logic clk = 0, rst_n = 0, awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
   logic clv = 0, stb = 1, tl = 0, err_sign, mirror;
   logic [3:0] aw = 0, ar = 0;
   logic [31:0] wd = 0;
   wire bv, rv, awr, wrdy, arr, pos, oe, neg, loff, gain, hold, flag;
   wire [1:0] bresp, rresp;
   wire [31:0] rdata;
   int num_errors = 0, check_count = 0;
   // 125 MHz clock
   always #4 clk = ~clk;
   track_jump_sequencer #(.KICK_CYC(K), .KICK_LONG_CYC(KL), .BRAKE_CYC(B)) u_track_jump_sequencer (
      .I_CLK(clk), .I_NRST(rst_n), .I_AWVALID(awv), .O_AWREADY(awr), .I_AWADDR(aw),
      .I_AWPROT(3'h0), .I_WVALID(wv), .O_WREADY(wrdy), .I_WDATA(wd), .I_WSTRB(4'hf),
      .O_BVALID(bv), .I_BREADY(br), .O_BRESP(bresp), .I_ARVALID(arv), .O_ARREADY(arr),
      .I_ARADDR(ar), .I_ARPROT(3'h0), .O_RVALID(rv), .I_RREADY(rr), .O_RDATA(rdata),
      .O_RRESP(rresp), .I_TRACK_ERROR_SIGN_IN(err_sign), .I_MIRROR_DETECT_IN(mirror),
      .I_CLV_MODE(clv), .I_HOST_COMMAND_STROBE_IN(stb), .O_JUMP_DRIVE_POS(pos),
      .O_JUMP_DRIVE_POS_OE(oe), .O_JUMP_DRIVE_NEG(neg), .O_TRACKING_LOOP_OFF_OUT(loff),
      .O_TRACKING_GAIN_BOOST_OUT(gain), .O_TRACKING_HOLD_OUT(hold),
      .O_HOST_STATUS_FLAG_OUT(flag));
   servo_front_end #(.HALF(P / 2)) u_servo_front_end (.clk(clk), .err_sign(err_sign),
      .mirror(mirror));
   // Compare, count and report
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      check_count++;
      if (s !== e)
      begin
         num_errors++;
         $display("[ERR] %0t seen %0h expected %0h", $time, s, e);
      end
   endtask
   task automatic end_of_test;
      $display("errors %0d checks %0d", num_errors, check_count);
      if (num_errors == 0 && check_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // Bus write and read
   task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] e);
      @(posedge clk);
      aw <= a;
      wd <= d;
      awv <= 1;
      wv <= 1;
      br <= 1;
      do
      begin
         @(posedge clk);
         if (awr) awv <= 0;
         if (wrdy) wv <= 0;
      end
      while (!bv);
      br <= 0;
      chk(bresp, e);
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] d, input logic [1:0] e);
      @(posedge clk);
      ar <= a;
      arv <= 1;
      rr <= 1;
      do
      begin
         @(posedge clk);
         if (arr) arv <= 0;
      end
      while (!rv);
      rr <= 0;
      chk(rresp, e);
      if (e == 0) chk(rdata, d);
   endtask
   // Reference accel plus decel cycles
   function automatic int ab(int c, int nw);
      case (c)
         'h11: return 2 * K;
         'h12, 'h31, 'h52: return P / 2 + (nw ? P / 2 : K);
         'h10: return nw ? 2 * P : 0;
         'h13: return 2 * P + (nw ? 2 * P : KL);
         'h14: return (nw ? 18 : 16) * P;
         'h30: return 32 * P;
         'h15: return 64 * P;
         'h17: return 128 * P;
         default: return 0;
      endcase
   endfunction
   function automatic int bk(int c, int nw, int sel);
      return (c == 'h31 || (c == 'h10 && !(nw && sel))) ? 0 : B;
   endfunction
   // One jump against the reference
   task automatic run(input int c, input int nw, input int sel);
      int h = 0, g = 0, q = 0, m = 0, t = 0, d, w;
      logic p;
      d = (c == 'h8c || c == 'h16) ? 0 : $urandom % 2;
      w = ab(c, nw) + bk(c, nw, sel) + (c == 'h16 ? 256 * P : 0) + 60;
      wr(0, 'ha0 + nw, 0);
      wr(0, c + 8 * d, 0);
      repeat (w)
      begin
         @(posedge clk);
         if (hold && h == 0) p = pos;
         if (hold) h++;
         if (gain) g++;
         if (gain && loff) t++;
         if (neg) m++;
         if (oe) q++;
      end
      chk(h, ab(c, nw));
      chk(g, bk(c, nw, sel));
      chk(q, tl ? h : w);
      if (tl) chk(m, 0);
      if (c == 'h52) chk(t, 0);
      else if (g > 0) chk(t > 0 && t < g, 1);
      if (h > 0 && !tl) chk(p, !d);
      rd(0, 0, 0);
   endtask
   // Repeating track check
   task automatic trk(input logic [7:0] c, input int n);
      int len, k;
      wr(0, c, 0);
      wr(0, n, 0);
      stb <= 0;
      repeat (5) @(posedge clk);
      stb <= 1;
      for (k = 0; k < 2; k++)
      begin
         len = 0;
         for (int j = 0; j < 6000 && !flag; j++) @(posedge clk);
         while (flag && len < 6000)
         begin
            @(posedge clk);
            len++;
         end
         chk(len, (n - n / 2) * P);
      end
      wr(0, 'hff, 0);
      wr(0, 'h8c, 0);
      len = 0;
      repeat (3000)
      begin
         @(posedge clk);
         if (flag) len++;
      end
      chk(len, 0);
   endtask
   // Main sequence
   initial
   begin
      int codes[12] = '{'h11, 'h12, 'h31, 'h52, 'h10, 'h13, 'h14, 'h30, 'h15, 'h17, 'h8c, 'h16};
      void'($urandom(32'hf764));
      repeat (20) @(posedge clk);
      rst_n <= 1;
      repeat (10) @(posedge clk);
      clv <= 1;
      repeat (60) @(posedge clk);
      rd(8, P, 0);
      wr('hc, 0, 3);
      rd('hc, 0, 3);
      foreach (codes[i])
         for (int nw = 0; nw < 2; nw++)
            run(codes[i], nw, 0);
      wr(0, 'h7f, 0);
      run('h10, 1, 1);
      wr(0, 'hf6, 0);
      run('h10, 1, 0);
      wr(0, 'h17, 0);
      repeat (50) @(posedge clk);
      run('h8c, 1, 0);
      tl = 1;
      wr(0, 'hb6, 0);
      run('h13, 1, 0);
      wr(0, 'hb7, 0);
      tl = 0;
      trk('hf0, 8);
      trk('hf8, 254);
      end_of_test;
   end
   // Watchdog
   initial
   begin
      repeat (90000) @(posedge clk);
      num_errors++;
      end_of_test;
   end
endmodule
`default_nettype wire
